// ==== rtl/tim_params.svh ====
`ifndef TIM_PARAMS_SVH
`define TIM_PARAMS_SVH
`define TIM_NPORTS        8
`define TIM_ADDR_W        13
`define TIM_ADDR_MSB      12
`define TIM_PORT_MSB      11
`define TIM_PORT_LSB      9
`define TIM_OFS_MSB       8
`define TIM_OFS_LSB       0
`define TIM_OFS_SOURCE    9'h19F
`define TIM_OFS_FMASK     9'h1A0
`define TIM_OFS_HMASK     9'h1A1
`define TIM_OFS_SMASK     9'h1A2
`define TIM_OFS_CODE1     9'h1AC
`define TIM_OFS_CODE2     9'h1AD
`define TIM_OFS_FLAGS     9'h1B1
`define TIM_OFS_FREE      9'h1B3
`define TIM_RESET_BYTE    8'h00
`define TIM_SMASK_KEEP    8'h01
`define TIM_E1_KEEP       8'hEF
`define TIM_KEEP5         8'hF8
`define TIM_KEEP6         8'hFC
`define TIM_KEEP7         8'hFE
`define TIM_FIFO_DEPTH    7'h40
`define TIM_LEVEL_EMPTY   7'h00
`define TIM_LAST5         4'h4
`define TIM_LAST6         4'h5
`define TIM_LAST7         4'h6
`define TIM_LAST16        4'hF
`define TIM_PAT_TOP       4'hF
`define TIM_CNT_ZERO      4'h0
`define TIM_CNT_STEP      4'h1
`define TIM_FIRST_BIT     7
`define TIM_T1ONLY_BIT    4
`endif

// ==== rtl/tim_pkg.sv ====
package tim_pkg;
   typedef enum logic [1:0] {TIM_LEN5, TIM_LEN6, TIM_LEN7, TIM_LEN16} tim_code_len_type;
   typedef logic [7:0] tim_byte_type;
   typedef logic [2:0] tim_group_type;
endpackage : tim_pkg

// ==== rtl/tim_top.sv ====
// Overview of operation
// - Source register bits 2,1,0 flag synchronizer, HDLC, framer groups pending.
// - Framer mask at 1A0h; 1 enables an event, 0 masks it.
// - Framer mask bit 3 enables density violation in T1, align frame in E1.
// - Bit 4 enables 72-frame event only in T1; other bits as listed.
// - HDLC mask at 1A1h; bit 4 datalink empty only in T1.
// - Synchronizer mask at 1A2h keeps only bit 0, frame sync loss.
// - Repeating code sent from bit 7 of first code register.
// - Low bits of first code register ignored for 5, 6, 7 bit lengths.
// - Six-bit length ignores bits 1 and 0 of first code register.
// - Second code register fully ignored for 5, 6 and 7 bit lengths.
// - Live flags at 1B1h: bit 3 empty, bit 2 full.
// - Live flag bit 1 high while FIFO level is below watermark.
// - Live flag bit 0 high while FIFO has a free byte.
// - Free byte count at 1B3h in bits 6 to 0, bit 7 zero.
// - Every register repeats per port at base plus 200h times port index.
// - Interrupt output low while any enabled latched bit is set.
// - Pending bits are live and clear once causes are cleared.
// - Below watermark event pulses on rising edge of live flag.
`include "tim_params.svh"
module tim_top
   import tim_pkg::*;
(
   input  wire logic                              clk_in,
   input  wire logic                              rstn_in,
   input  wire logic [`TIM_ADDR_MSB:0]            addr_in,
   input  wire logic                              wr_in,
   input  wire logic                              rd_in,
   input  wire logic [7:0]                        wdata_in,
   output logic      [7:0]                        rdata_out,
   input  wire logic [`TIM_NPORTS-1:0]            t1_mode_in,
   input  wire logic [`TIM_NPORTS-1:0][7:0]       framer_latched_group_in,
   input  wire logic [`TIM_NPORTS-1:0][7:0]       hdlc_latched_group_in,
   input  wire logic [`TIM_NPORTS-1:0][7:0]       sync_latched_group_in,
   input  wire logic [`TIM_NPORTS-1:0][6:0]       fifo_level_in,
   input  wire logic [`TIM_NPORTS-1:0][6:0]       watermark_in,
   input  wire logic [`TIM_NPORTS-1:0][1:0]       code_len_in,
   input  wire logic [`TIM_NPORTS-1:0]            bit_tick_in,
   output logic      [`TIM_NPORTS-1:0]            code_bit_out,
   output logic      [`TIM_NPORTS-1:0]            below_watermark_rise_out,
   output logic                                   interrupt_out_n
);

   logic                                rst_meta;
   logic                                rst_n;
   logic [`TIM_NPORTS-1:0][7:0]         framer_event_mask;
   logic [`TIM_NPORTS-1:0][7:0]         hdlc_event_mask;
   logic [`TIM_NPORTS-1:0][7:0]         synchronizer_event_mask;
   logic [`TIM_NPORTS-1:0][7:0]         code_pattern_first;
   logic [`TIM_NPORTS-1:0][7:0]         code_pattern_second;
   logic [`TIM_NPORTS-1:0][7:0]         interrupt_source_groups;
   logic [`TIM_NPORTS-1:0][7:0]         hdlc_fifo_live_flags;
   logic [`TIM_NPORTS-1:0][7:0]         fifo_free_count;
   logic [`TIM_NPORTS-1:0]              below_watermark_flag;
   logic [`TIM_NPORTS-1:0]              below_prev;
   logic [`TIM_NPORTS-1:0]              port_pending;
   logic [`TIM_NPORTS-1:0][15:0]        pattern;
   logic [`TIM_NPORTS-1:0][3:0]         bit_cnt;
   logic [`TIM_NPORTS-1:0][3:0]         last_cnt;
   logic [2:0]                          sel_port;
   logic [8:0]                          sel_ofs;
   logic                                sel_hit;
   tim_byte_type                        next_rdata;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n);

   // Reset release through two flops
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Port index and offset split
   assign sel_port = addr_in[`TIM_PORT_MSB:`TIM_PORT_LSB];
   assign sel_ofs  = addr_in[`TIM_OFS_MSB:`TIM_OFS_LSB];
   assign sel_hit  = ~addr_in[`TIM_ADDR_MSB];

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         framer_event_mask       <= '0;
         hdlc_event_mask         <= '0;
         synchronizer_event_mask <= '0;
         code_pattern_first      <= '0;
         code_pattern_second     <= '0;
      end else if (wr_in && sel_hit) begin
         case (sel_ofs)
            `TIM_OFS_FMASK: framer_event_mask[sel_port] <= wdata_in;
            `TIM_OFS_HMASK: hdlc_event_mask[sel_port] <= wdata_in;
            `TIM_OFS_SMASK: begin
               synchronizer_event_mask[sel_port] <= wdata_in & `TIM_SMASK_KEEP;
            end
            `TIM_OFS_CODE1: code_pattern_first[sel_port] <= wdata_in;
            `TIM_OFS_CODE2: code_pattern_second[sel_port] <= wdata_in;
            default: ;
         endcase
      end
   end

   genvar p;
   generate
      for (p = 0; p < `TIM_NPORTS; p++) begin : g_port
         logic [7:0] fm_eff;
         logic [7:0] hm_eff;
         tim_code_len_type len;

         // T1-only bits are held masked in E1 mode
         assign fm_eff = t1_mode_in[p] ? framer_event_mask[p]
                                       : (framer_event_mask[p] & `TIM_E1_KEEP);
         assign hm_eff = t1_mode_in[p] ? hdlc_event_mask[p]
                                       : (hdlc_event_mask[p] & `TIM_E1_KEEP);
         assign interrupt_source_groups[p] = {5'h00,
            |(sync_latched_group_in[p] & synchronizer_event_mask[p]),
            |(hdlc_latched_group_in[p] & hm_eff),
            |(framer_latched_group_in[p] & fm_eff)};
         assign port_pending[p] = |interrupt_source_groups[p];

         assign below_watermark_flag[p] = fifo_level_in[p] < watermark_in[p];
         assign hdlc_fifo_live_flags[p] = {4'h0,
            fifo_level_in[p] == `TIM_LEVEL_EMPTY,
            fifo_level_in[p] >= `TIM_FIFO_DEPTH,
            below_watermark_flag[p],
            fifo_level_in[p] < `TIM_FIFO_DEPTH};
         assign fifo_free_count[p] = {1'b0,
            (fifo_level_in[p] >= `TIM_FIFO_DEPTH) ? 7'h00
                                                  : (`TIM_FIFO_DEPTH - fifo_level_in[p])};

         always_ff @(posedge clk_in or negedge rst_n) begin
            if (!rst_n) begin
               below_prev[p]               <= 1'b0;
               below_watermark_rise_out[p] <= 1'b0;
            end else begin
               below_prev[p]               <= below_watermark_flag[p];
               below_watermark_rise_out[p] <= below_watermark_flag[p] & ~below_prev[p];
            end
         end

         assign len = tim_code_len_type'(code_len_in[p]);
         always_comb begin
            case (len)
               TIM_LEN5: begin
                  pattern[p]  = {code_pattern_first[p] & `TIM_KEEP5, 8'h00};
                  last_cnt[p] = `TIM_LAST5;
               end
               TIM_LEN6: begin
                  pattern[p]  = {code_pattern_first[p] & `TIM_KEEP6, 8'h00};
                  last_cnt[p] = `TIM_LAST6;
               end
               TIM_LEN7: begin
                  pattern[p]  = {code_pattern_first[p] & `TIM_KEEP7, 8'h00};
                  last_cnt[p] = `TIM_LAST7;
               end
               default: begin
                  pattern[p]  = {code_pattern_first[p], code_pattern_second[p]};
                  last_cnt[p] = `TIM_LAST16;
               end
            endcase
         end

         // Serialiser, pattern sent MSB first
         always_ff @(posedge clk_in or negedge rst_n) begin
            if (!rst_n) begin
               bit_cnt[p]      <= `TIM_CNT_ZERO;
               code_bit_out[p] <= 1'b0;
            end else if (bit_tick_in[p]) begin
               code_bit_out[p] <= pattern[p][`TIM_PAT_TOP - bit_cnt[p]];
               bit_cnt[p] <= (bit_cnt[p] >= last_cnt[p]) ? `TIM_CNT_ZERO
                                                         : bit_cnt[p] + `TIM_CNT_STEP;
            end
         end

         // Per-port checks
         sequence s_one_pulse;
            below_watermark_rise_out[p] ##1 !below_watermark_rise_out[p];
         endsequence

         a_code_first_bit: assert property (bit_tick_in[p] && bit_cnt[p] == `TIM_CNT_ZERO
            |=> code_bit_out[p] == $past(code_pattern_first[p][`TIM_FIRST_BIT]))
            else $error("code did not start at first register bit 7");
         a_code_short_mask: assert property (len != TIM_LEN16
            |-> pattern[p][7:0] == 8'h00 && (len != TIM_LEN5 || pattern[p][10:8] == 3'h0))
            else $error("ignored code bits leaked into pattern");
         a_code_six_mask: assert property (len == TIM_LEN6 |-> pattern[p][9:8] == 2'h0)
            else $error("six bit code kept low bits");
         a_code_wrap: assert property (len == TIM_LEN5 && bit_tick_in[p]
            && bit_cnt[p] == `TIM_LAST5 |=> bit_cnt[p] == `TIM_CNT_ZERO)
            else $error("five bit code did not wrap");
         a_wm_rise_pulse: assert property ($rose(below_watermark_flag[p])
            |=> s_one_pulse)
            else $error("watermark edge pulse wrong");
         a_e1_mask_hold: assert property (!t1_mode_in[p]
            && (framer_latched_group_in[p] | hdlc_latched_group_in[p]) == 8'h10
            |-> !interrupt_source_groups[p][0] && !interrupt_source_groups[p][1])
            else $error("T1-only event raised pending in E1");
         a_framer_bit3: assert property (framer_latched_group_in[p] == 8'h08
            |-> interrupt_source_groups[p][0] == framer_event_mask[p][3])
            else $error("framer bit 3 gating wrong");
         a_hdlc_group: assert property (hdlc_latched_group_in[p] == 8'h08
            |-> interrupt_source_groups[p][1] == hdlc_event_mask[p][3])
            else $error("hdlc group pending wrong");
         a_smask_unused: assert property (synchronizer_event_mask[p][7:1] == 7'h00)
            else $error("sync mask holds unused bits");
         a_flags_empty: assert property (fifo_level_in[p] == `TIM_LEVEL_EMPTY
            |-> hdlc_fifo_live_flags[p][3] && !hdlc_fifo_live_flags[p][2])
            else $error("empty flag wrong");
         a_flags_full: assert property (fifo_level_in[p] == `TIM_FIFO_DEPTH
            |-> hdlc_fifo_live_flags[p][2] && !hdlc_fifo_live_flags[p][0])
            else $error("full flag wrong");
         a_free_sum: assert property (fifo_level_in[p] <= `TIM_FIFO_DEPTH
            |-> fifo_free_count[p][6:0] + fifo_level_in[p] == `TIM_FIFO_DEPTH
                && !fifo_free_count[p][7])
            else $error("free count and level disagree");
      end
   endgenerate

   always_comb begin
      next_rdata = `TIM_RESET_BYTE;
      if (sel_hit) begin
         case (sel_ofs)
            `TIM_OFS_SOURCE: next_rdata = interrupt_source_groups[sel_port];
            `TIM_OFS_FMASK:  next_rdata = framer_event_mask[sel_port];
            `TIM_OFS_HMASK:  next_rdata = hdlc_event_mask[sel_port];
            `TIM_OFS_SMASK:  next_rdata = synchronizer_event_mask[sel_port];
            `TIM_OFS_CODE1:  next_rdata = code_pattern_first[sel_port];
            `TIM_OFS_CODE2:  next_rdata = code_pattern_second[sel_port];
            `TIM_OFS_FLAGS:  next_rdata = hdlc_fifo_live_flags[sel_port];
            `TIM_OFS_FREE:   next_rdata = fifo_free_count[sel_port];
            default:         next_rdata = `TIM_RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_out <= `TIM_RESET_BYTE;
      end else if (rd_in) begin
         rdata_out <= next_rdata;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_out_n <= 1'b1;
      end else begin
         interrupt_out_n <= ~(|port_pending);
      end
   end

   sequence s_read_at(logic [8:0] ofs);
      rd_in && sel_hit && sel_ofs == ofs;
   endsequence

   sequence s_write_at(logic [8:0] ofs);
      wr_in && sel_hit && sel_ofs == ofs;
   endsequence

   // Register bus checks
   a_src_readback: assert property (s_read_at(`TIM_OFS_SOURCE)
      |=> rdata_out == $past(interrupt_source_groups[sel_port]))
      else $error("source register read mismatch");
   a_fmask_store: assert property (s_write_at(`TIM_OFS_FMASK)
      ##1 s_read_at(`TIM_OFS_FMASK) ##0 (sel_port == $past(sel_port))
      |=> rdata_out == $past(wdata_in, 2))
      else $error("framer mask did not store");
   a_hmask_store: assert property (s_write_at(`TIM_OFS_HMASK)
      |=> hdlc_event_mask[$past(sel_port)] == $past(wdata_in))
      else $error("hdlc mask did not store");
   a_smask_bits: assert property (s_write_at(`TIM_OFS_SMASK)
      |=> synchronizer_event_mask[$past(sel_port)] == ($past(wdata_in) & `TIM_SMASK_KEEP))
      else $error("sync mask kept unused bits");
   a_code1_store: assert property (s_write_at(`TIM_OFS_CODE1)
      |=> code_pattern_first[$past(sel_port)] == $past(wdata_in))
      else $error("first code register did not store");
   a_code2_store: assert property (s_write_at(`TIM_OFS_CODE2)
      |=> code_pattern_second[$past(sel_port)] == $past(wdata_in))
      else $error("second code register did not store");
   a_refused_write: assert property (wr_in && !sel_hit
      |=> $stable(framer_event_mask) && $stable(hdlc_event_mask))
      else $error("write outside the map landed");
   a_flags_read: assert property (s_read_at(`TIM_OFS_FLAGS)
      |=> rdata_out[7:4] == 4'h0
          && rdata_out[3] == ($past(fifo_level_in[sel_port]) == 7'h00)
          && rdata_out[0] == ($past(fifo_level_in[sel_port]) < 7'h40))
      else $error("live flags wrong");
   a_below_read: assert property (s_read_at(`TIM_OFS_FLAGS)
      |=> rdata_out[1] == ($past(fifo_level_in[sel_port]) < $past(watermark_in[sel_port])))
      else $error("below watermark flag wrong");
   a_free_read: assert property (s_read_at(`TIM_OFS_FREE)
      ##0 (fifo_level_in[sel_port] <= `TIM_FIFO_DEPTH)
      |=> rdata_out == {1'b0, `TIM_FIFO_DEPTH - $past(fifo_level_in[sel_port])})
      else $error("free count wrong");
   a_irq_assert: assert property (|port_pending |=> !interrupt_out_n)
      else $error("interrupt not driven low");
   a_irq_idle: assert property (!(|port_pending) |=> interrupt_out_n)
      else $error("interrupt low with nothing pending");
   a_irq_release: assert property ($fell(|port_pending) |=> interrupt_out_n)
      else $error("interrupt not released");

endmodule // tim_top

// ==== bench/tim_top_tb_top.sv ====
`include "tim_params.svh"
module tim_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [12:0] addr; logic [7:0] wdata; logic [7:0] exp;} tim_row_type;
   logic                         clk_in, rstn_in, wr_in, rd_in, interrupt_out_n;
   logic [`TIM_ADDR_MSB:0]       addr_in;
   logic [7:0]                   wdata_in, rdata_out;
   logic [`TIM_NPORTS-1:0]       t1_mode_in, bit_tick_in, code_bit_out, rise_out;
   logic [`TIM_NPORTS-1:0][7:0]  fl_in, hl_in, sl_in;
   logic [`TIM_NPORTS-1:0][6:0]  lvl_in, wm_in;
   logic [`TIM_NPORTS-1:0][1:0]  len_in;
   int                           num_errors = 0;
   int                           checks_done = 0;
   int                           cycles = 0;
   int                           n;
   logic [8:0]                   ofs [5] = '{9'h1A0, 9'h1A1, 9'h1A2, 9'h1AC, 9'h1AD};
   logic [7:0]                   pat [4] = '{8'hBF, 8'hBB, 8'hB9, 8'hC3};
   logic [15:0]                  cw;
   int                           cl;
   // Write, then read back the same place
   tim_row_type rows [10] = '{
      '{13'h01A0, 8'hA5, 8'hA5}, '{13'h03A1, 8'h1F, 8'h1F}, '{13'h05A2, 8'hFF, 8'h01},
      '{13'h07AC, 8'hB8, 8'hB8}, '{13'h09AD, 8'h3C, 8'h3C}, '{13'h0FA0, 8'h5A, 8'h5A},
      '{13'h0BB1, 8'hFF, 8'h09}, '{13'h0DB3, 8'h00, 8'h40}, '{13'h01A3, 8'hFF, 8'h00},
      '{13'h11A0, 8'h00, 8'h00}};

   tim_top tim_top_inst (
      .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
      .wdata_in(wdata_in), .rdata_out(rdata_out), .t1_mode_in(t1_mode_in),
      .framer_latched_group_in(fl_in), .hdlc_latched_group_in(hl_in),
      .sync_latched_group_in(sl_in), .fifo_level_in(lvl_in), .watermark_in(wm_in),
      .code_len_in(len_in), .bit_tick_in(bit_tick_in), .code_bit_out(code_bit_out),
      .below_watermark_rise_out(rise_out), .interrupt_out_n(interrupt_out_n));

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   function automatic logic [12:0] ad(input int p, input logic [8:0] o);
      return {1'b0, p[2:0], o};
   endfunction

   task automatic step;
      @(posedge clk_in);
      #2;
   endtask

   task automatic end_sim;
      if (num_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      addr_in = a;
      wdata_in = d;
      wr_in = 1'b1;
      step;
      wr_in = 1'b0;
   endtask

   task automatic rd(input logic [12:0] a, input logic [7:0] e, input string nm);
      addr_in = a;
      rd_in = 1'b1;
      step;
      rd_in = 1'b0;
      chk(nm, e, rdata_out);
      step;
   endtask

   // Raise one port's latched groups, check source and output, then clear
   task automatic irq(input int p, input logic [7:0] f, h, s, input logic t1,
                      input logic [2:0] e);
      fl_in[p] = f;
      hl_in[p] = h;
      sl_in[p] = s;
      t1_mode_in[p] = t1;
      step;
      step;
      chk("int_n", {7'h00, e == 3'h0}, {7'h00, interrupt_out_n});
      rd(ad(p, `TIM_OFS_SOURCE), {5'h00, e}, "source");
      fl_in[p] = 8'h00;
      hl_in[p] = 8'h00;
      sl_in[p] = 8'h00;
      step;
      step;
      chk("int_n_release", 8'h01, {7'h00, interrupt_out_n});
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         end_sim;
      end
   end

   initial begin
      rstn_in = 1'b0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = '0;
      wdata_in = '0;
      t1_mode_in = '1;
      bit_tick_in = '0;
      fl_in = '0;
      hl_in = '0;
      sl_in = '0;
      lvl_in = '0;
      wm_in = '0;
      len_in = '0;
      repeat (20) @(posedge clk_in);
      #2;
      rstn_in = 1'b1;
      repeat (3) step;
      foreach (ofs[j]) rd(ad(j, ofs[j]), 8'h00, "reset_value");
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rows[i].exp, "register");
      end
      rd(ad(0, `TIM_OFS_FMASK), 8'hA5, "refused_write");
      irq(0, 8'h5A, 8'h00, 8'h00, 1'b1, 3'h0);
      irq(0, 8'h81, 8'h00, 8'h00, 1'b1, 3'h1);
      irq(1, 8'h00, 8'h10, 8'h00, 1'b1, 3'h2);
      irq(1, 8'h00, 8'h10, 8'h00, 1'b0, 3'h0);
      irq(1, 8'h00, 8'h08, 8'h00, 1'b0, 3'h2);
      irq(2, 8'h00, 8'h00, 8'hFE, 1'b1, 3'h0);
      irq(2, 8'h00, 8'h00, 8'h01, 1'b1, 3'h4);
      irq(7, 8'h08, 8'h00, 8'h00, 1'b0, 3'h1);
      irq(7, 8'h10, 8'h00, 8'h00, 1'b1, 3'h1);
      irq(7, 8'h10, 8'h00, 8'h00, 1'b0, 3'h0);
      lvl_in[3] = 7'h40;
      wm_in[3] = 7'h10;
      step;
      rd(ad(3, `TIM_OFS_FLAGS), 8'h04, "flags_full");
      rd(ad(3, `TIM_OFS_FREE), 8'h00, "free_full");
      lvl_in[3] = 7'h0A;
      n = 0;
      repeat (4) begin
         step;
         if (rise_out[3] === 1'b1) n++;
      end
      chk("below_rise_pulses", 8'h01, n[7:0]);
      rd(ad(3, `TIM_OFS_FLAGS), 8'h03, "flags_below");
      rd(ad(3, `TIM_OFS_FREE), 8'h36, "free_count");
      lvl_in[3] = 7'h00;
      step;
      rd(ad(3, `TIM_OFS_FLAGS), 8'h0B, "flags_empty");
      for (int k = 0; k < 4; k++) begin
         len_in[3] = k[1:0];
         cl = (k < 3) ? k + 5 : 16;
         cw = {pat[k], 8'h55};
         wr(ad(3, `TIM_OFS_CODE1), pat[k]);
         step;
         wr(ad(3, `TIM_OFS_CODE2), 8'h55);
         for (int i = 0; i < 2 * cl; i++) begin
            bit_tick_in[3] = 1'b1;
            step;
            bit_tick_in[3] = 1'b0;
            step;
            chk("code_bit", {7'h00, cw[15 - (i % cl)]}, {7'h00, code_bit_out[3]});
         end
      end
      // Mid-run reset with an enabled cause standing
      fl_in[0] = 8'h01;
      step;
      step;
      chk("int_n_set", 8'h00, {7'h00, interrupt_out_n});
      rstn_in = 1'b0;
      step;
      chk("int_n_reset", 8'h01, {7'h00, interrupt_out_n});
      rstn_in = 1'b1;
      repeat (3) step;
      rd(ad(0, `TIM_OFS_SOURCE), 8'h00, "source_after_reset");
      rd(ad(3, `TIM_OFS_CODE1), 8'h00, "code1_after_reset");
      end_sim;
   end
endmodule // tim_top_tb_top
